// >>> hw/dual_dac_slew_register_map.sv
// holding registers, slew engines and serial delay timers of the two channel output module
// assumes a same-clock protocol engine drives the register port, RX_CHAR and REPLY_REQ
`timescale 1ns/10ps

// ************************************************************
// one slewing output channel
// ************************************************************
module slew_channel (
    // clock and control
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic tick,
    // target and rate
    input wire logic [15:0] target,
    input wire logic [4:0] code,
    // present value
    output logic [15:0] level
);
    logic [31:0] acc_r;
    logic [31:0] acc_nxt;
    logic [31:0] target_q;
    logic [31:0] step;
    logic [31:0] gap_up;
    logic [31:0] gap_dn;

    // rate per ms halves for every code below the top one
    assign target_q = {target, 16'h0000};
    assign step = dual_dac_slew_pkg::STEP_TOP_Q16 >> (dual_dac_slew_pkg::SLOPE_CODE_TOP - code); // R7 R9
    assign gap_up = target_q - acc_r;
    assign gap_dn = acc_r - target_q;

    // clamp the final step onto the target so it never overshoots
    always_comb begin
        acc_nxt = acc_r;
        if (code == 5'h00) begin
            acc_nxt = target_q; // R7
        end else if (tick) begin
            if (acc_r < target_q) begin
                acc_nxt = (step >= gap_up) ? target_q : acc_r + step; // R13
            end else if (acc_r > target_q) begin
                acc_nxt = (step >= gap_dn) ? target_q : acc_r - step; // R13
            end
        end
    end

    // accumulator in 16.16 fixed point
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            acc_r <= {dual_dac_slew_pkg::SETPOINT_RST, 16'h0000};
        end else if (ce) begin
            acc_r <= acc_nxt;
        end
    end

    assign level = acc_r[31:16];
endmodule : slew_channel

// ************************************************************
// register map top
// ************************************************************
module dual_dac_slew_register_map #(
    parameter int unsigned MS_CYC = dual_dac_slew_pkg::MS_CYC_DFLT,
    parameter int unsigned GAP_CYC = dual_dac_slew_pkg::GAP_CYC_DFLT,
    parameter logic [15:0] FW_VERSION = 16'h0A5C // arbitrary value
) (
    // clock, reset, enable
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic CE,
    // register port
    input wire logic [15:0] REG_ADDR,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [15:0] REG_WDATA,
    output logic [15:0] REG_RDATA,
    output logic REG_ACK,
    output logic REG_ERR,
    // nonvolatile slope defaults
    input wire logic [15:0] SLOPE_NV_CH1,
    input wire logic [15:0] SLOPE_NV_CH2,
    // output measurement pins
    input wire logic [7:0] ADC_PIN_CH1,
    input wire logic [7:0] ADC_PIN_CH2,
    // converter values
    output logic [15:0] DAC_CH1,
    output logic [15:0] DAC_CH2,
    // serial link setup
    output logic [15:0] NODE_ADDR,
    output logic [15:0] FRAMING_SETUP,
    // framing and reply timing
    input wire logic RX_CHAR,
    output logic FRAME_END,
    input wire logic REPLY_REQ,
    output logic REPLY_GO
);
    logic [15:0] node_addr_r;
    logic [15:0] framing_r;
    logic [15:0] delays_r;
    logic [15:0] setpoint1_r;
    logic [15:0] setpoint2_r;
    logic [15:0] slope1_r;
    logic [15:0] slope2_r;
    logic nv_loaded_r;
    logic [7:0] adc1_meta_r;
    logic [7:0] adc1_sync_r;
    logic [7:0] adc2_meta_r;
    logic [7:0] adc2_sync_r;
    logic [31:0] tick_cnt_r;
    logic slew_tick;
    logic [4:0] code1;
    logic [4:0] code2;
    logic [31:0] gap_cnt_r;
    logic [31:0] gap_lim;
    logic armed_r;
    dual_dac_slew_pkg::reply_state_e reply_state_r;
    logic [7:0] reply_left_r;
    logic [31:0] reply_cyc_r;
    logic [7:0] reply_ms;
    logic [7:0] eoq_ms;

    // ************************************************************
    // address decode and write checks
    // ************************************************************
    logic hit_node, hit_fram, hit_dly, hit_ver, hit_sp1, hit_sp2, hit_sl1, hit_sl2;
    logic hit_rb1, hit_rb2, hit_lv1, hit_lv2, map_hit, ro_hit;
    logic node_ok, fram_ok, dly_ok, slope_ok, val_ok, wr_ok, rd_ok;
    logic [15:0] rd_val;

    // one compare per mapped register
    assign hit_node = REG_ADDR == dual_dac_slew_pkg::OFS_NODE_ADDR;
    assign hit_fram = REG_ADDR == dual_dac_slew_pkg::OFS_FRAMING;
    assign hit_dly = REG_ADDR == dual_dac_slew_pkg::OFS_DELAYS;
    assign hit_ver = REG_ADDR == dual_dac_slew_pkg::OFS_VERSION;
    assign hit_sp1 = REG_ADDR == dual_dac_slew_pkg::OFS_SETPOINT1;
    assign hit_sp2 = REG_ADDR == dual_dac_slew_pkg::OFS_SETPOINT2;
    assign hit_sl1 = REG_ADDR == dual_dac_slew_pkg::OFS_SLOPE1;
    assign hit_sl2 = REG_ADDR == dual_dac_slew_pkg::OFS_SLOPE2;
    assign hit_rb1 = REG_ADDR == dual_dac_slew_pkg::OFS_READBACK1;
    assign hit_rb2 = REG_ADDR == dual_dac_slew_pkg::OFS_READBACK2;
    assign hit_lv1 = REG_ADDR == dual_dac_slew_pkg::OFS_LIVE1;
    assign hit_lv2 = REG_ADDR == dual_dac_slew_pkg::OFS_LIVE2;
    assign ro_hit = hit_ver | hit_rb1 | hit_rb2 | hit_lv1 | hit_lv2; // R10 R11 R12
    assign map_hit = ro_hit | hit_node | hit_fram | hit_dly | hit_sp1 | hit_sp2 | hit_sl1 | hit_sl2;

    // out-of-range values are refused and leave the register alone
    assign node_ok = (REG_WDATA >= dual_dac_slew_pkg::NODE_ADDR_MIN)
                   && (REG_WDATA <= dual_dac_slew_pkg::NODE_ADDR_MAX); // R1
    assign fram_ok = (REG_WDATA[3:0] >= dual_dac_slew_pkg::BAUD_CODE_MIN)
                   && (REG_WDATA[3:0] <= dual_dac_slew_pkg::BAUD_CODE_MAX); // R2
    assign dly_ok = (REG_WDATA[7:0] <= dual_dac_slew_pkg::REPLY_DLY_MAX_MS)
                  && (REG_WDATA[15:8] <= dual_dac_slew_pkg::EOQ_DLY_MAX_MS); // R3 R4
    assign slope_ok = REG_WDATA <= {11'h000, dual_dac_slew_pkg::SLOPE_CODE_TOP}; // R7
    assign val_ok = hit_node ? node_ok : hit_fram ? fram_ok : hit_dly ? dly_ok
                  : (hit_sl1 | hit_sl2) ? slope_ok : 1'b1;
    assign wr_ok = REG_WR & map_hit & ~ro_hit & val_ok;
    assign rd_ok = REG_RD & ~REG_WR & map_hit;

    // read selection
    assign rd_val = hit_node ? node_addr_r
                  : hit_fram ? framing_r
                  : hit_dly ? delays_r
                  : hit_ver ? FW_VERSION // R12
                  : hit_sp1 ? setpoint1_r
                  : hit_sp2 ? setpoint2_r
                  : hit_sl1 ? slope1_r
                  : hit_sl2 ? slope2_r
                  : hit_rb1 ? {adc1_sync_r, dual_dac_slew_pkg::READBACK_LOW} // R10
                  : hit_rb2 ? {adc2_sync_r, dual_dac_slew_pkg::READBACK_LOW} // R10
                  : hit_lv1 ? DAC_CH1 // R11
                  : DAC_CH2; // R11

    // ************************************************************
    // holding registers
    // ************************************************************
    // link setup and setpoints
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            node_addr_r <= dual_dac_slew_pkg::NODE_ADDR_RST; // R1
            framing_r <= dual_dac_slew_pkg::FRAMING_RST; // R2
            delays_r <= dual_dac_slew_pkg::DELAYS_RST; // R3 R4
            setpoint1_r <= dual_dac_slew_pkg::SETPOINT_RST;
            setpoint2_r <= dual_dac_slew_pkg::SETPOINT_RST;
        end else if (CE && wr_ok) begin
            if (hit_node) node_addr_r <= REG_WDATA; // R1
            if (hit_fram) framing_r <= REG_WDATA; // R2
            if (hit_dly) delays_r <= REG_WDATA; // R3 R4
            if (hit_sp1) setpoint1_r <= REG_WDATA; // R6
            if (hit_sp2) setpoint2_r <= REG_WDATA; // R6
        end
    end

    // slopes: stored default fetched at the first enabled edge, later writes act at once
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            slope1_r <= dual_dac_slew_pkg::SLOPE_RST;
            slope2_r <= dual_dac_slew_pkg::SLOPE_RST;
            nv_loaded_r <= 1'b0;
        end else if (CE) begin
            nv_loaded_r <= 1'b1;
            if (wr_ok && hit_sl1) begin
                slope1_r <= REG_WDATA; // R8
            end else if (!nv_loaded_r) begin
                slope1_r <= SLOPE_NV_CH1; // R8
            end
            if (wr_ok && hit_sl2) begin
                slope2_r <= REG_WDATA; // R8
            end else if (!nv_loaded_r) begin
                slope2_r <= SLOPE_NV_CH2; // R8
            end
        end
    end

    // answer one edge after the request
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            REG_ACK <= 1'b0;
            REG_ERR <= 1'b0;
            REG_RDATA <= 16'h0000;
        end else if (CE) begin
            REG_ACK <= wr_ok | rd_ok;
            REG_ERR <= (REG_WR | REG_RD) & ~(wr_ok | rd_ok); // R11
            if (rd_ok) REG_RDATA <= rd_val;
        end
    end

    assign NODE_ADDR = node_addr_r;
    assign FRAMING_SETUP = framing_r;

    // ************************************************************
    // measurement synchronisers
    // ************************************************************
    // two flops per pin before anything reads the value
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            adc1_meta_r <= 8'h00;
            adc1_sync_r <= 8'h00;
            adc2_meta_r <= 8'h00;
            adc2_sync_r <= 8'h00;
        end else if (CE) begin
            adc1_meta_r <= ADC_PIN_CH1;
            adc1_sync_r <= adc1_meta_r; // R10
            adc2_meta_r <= ADC_PIN_CH2;
            adc2_sync_r <= adc2_meta_r; // R10
        end
    end

    // ************************************************************
    // slew engines
    // ************************************************************
    // free running millisecond tick paces both channels
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            tick_cnt_r <= 32'h00000000;
        end else if (CE) begin
            tick_cnt_r <= slew_tick ? 32'h00000000 : tick_cnt_r + 32'h00000001;
        end
    end

    assign slew_tick = tick_cnt_r == 32'(MS_CYC - 1);
    // codes above the top one, possible only from storage, run at the top rate
    assign code1 = (slope1_r > {11'h000, dual_dac_slew_pkg::SLOPE_CODE_TOP})
                 ? dual_dac_slew_pkg::SLOPE_CODE_TOP : slope1_r[4:0]; // R7
    assign code2 = (slope2_r > {11'h000, dual_dac_slew_pkg::SLOPE_CODE_TOP})
                 ? dual_dac_slew_pkg::SLOPE_CODE_TOP : slope2_r[4:0]; // R7

    slew_channel u_ch1 (
        .clk(CLK),
        .rst(SYS_RST),
        .ce(CE),
        .tick(slew_tick),
        .target(setpoint1_r),
        .code(code1),
        .level(DAC_CH1)
    );

    slew_channel u_ch2 (
        .clk(CLK),
        .rst(SYS_RST),
        .ce(CE),
        .tick(slew_tick),
        .target(setpoint2_r),
        .code(code2),
        .level(DAC_CH2)
    );

    // ************************************************************
    // end of request detection
    // ************************************************************
    assign eoq_ms = delays_r[dual_dac_slew_pkg::EOQ_DLY_LSB +: 8];
    assign reply_ms = delays_r[dual_dac_slew_pkg::REPLY_DLY_LSB +: 8];
    assign gap_lim = 32'(GAP_CYC) + 32'(eoq_ms) * 32'(MS_CYC); // R4 R5

    // silence counter restarted by every character, fires once per request
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            gap_cnt_r <= 32'h00000000;
            armed_r <= 1'b0;
            FRAME_END <= 1'b0;
        end else if (CE) begin
            FRAME_END <= 1'b0;
            if (RX_CHAR) begin
                gap_cnt_r <= 32'h00000000; // R5
                armed_r <= 1'b1;
            end else if (armed_r) begin
                gap_cnt_r <= gap_cnt_r + 32'h00000001;
                if (gap_cnt_r == gap_lim) begin
                    FRAME_END <= 1'b1; // R5
                    armed_r <= 1'b0;
                end
            end
        end
    end

    // ************************************************************
    // reply delay
    // ************************************************************
    // a fresh request restarts the wait; a zero delay answers on the next edge
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            reply_state_r <= dual_dac_slew_pkg::REPLY_IDLE;
            reply_left_r <= 8'h00;
            reply_cyc_r <= 32'h00000000;
            REPLY_GO <= 1'b0;
        end else if (CE) begin
            REPLY_GO <= 1'b0;
            if (REPLY_REQ) begin
                reply_state_r <= dual_dac_slew_pkg::REPLY_WAIT;
                reply_left_r <= reply_ms; // R3
                reply_cyc_r <= 32'h00000000;
            end else begin
                case (reply_state_r)
                    dual_dac_slew_pkg::REPLY_WAIT: begin
                        if (reply_left_r == 8'h00) begin
                            REPLY_GO <= 1'b1; // R3
                            reply_state_r <= dual_dac_slew_pkg::REPLY_IDLE;
                        end else if (reply_cyc_r == 32'(MS_CYC - 1)) begin
                            reply_cyc_r <= 32'h00000000;
                            reply_left_r <= reply_left_r - 8'h01;
                        end else begin
                            reply_cyc_r <= reply_cyc_r + 32'h00000001;
                        end
                    end
                    default: begin
                        reply_state_r <= dual_dac_slew_pkg::REPLY_IDLE;
                    end
                endcase
            end
        end
    end

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);

    a_node_range: assert property (node_addr_r >= dual_dac_slew_pkg::NODE_ADDR_MIN
        && node_addr_r <= dual_dac_slew_pkg::NODE_ADDR_MAX) else $error("node address out of range"); // R1
    a_framing_baud: assert property (framing_r[3:0] >= dual_dac_slew_pkg::BAUD_CODE_MIN
        && framing_r[3:0] <= dual_dac_slew_pkg::BAUD_CODE_MAX) else $error("framing code out of range"); // R2
    a_reply_zero_delay: assert property ((CE && REPLY_REQ && reply_ms == 8'h00) ##1 (CE && !REPLY_REQ)
        |=> REPLY_GO) else $error("zero reply delay not answered at once"); // R3
    a_eoq_limit: assert property (eoq_ms <= dual_dac_slew_pkg::EOQ_DLY_MAX_MS)
        else $error("end of query delay above limit"); // R4
    a_frame_gap: assert property ($rose(FRAME_END) |-> $past(gap_cnt_r) == $past(gap_lim))
        else $error("frame end before the gap limit"); // R5
    a_rx_blocks_end: assert property ((CE && RX_CHAR) |=> !FRAME_END)
        else $error("frame end right after a character"); // R5
    a_setpoint_write: assert property ((CE && wr_ok && hit_sp1) |=> setpoint1_r == $past(REG_WDATA) && REG_ACK)
        else $error("setpoint write lost"); // R6
    a_slope_immediate: assert property ((CE && code1 == 5'h00) |=> DAC_CH1 == $past(setpoint1_r))
        else $error("zero slope did not apply setpoint"); // R7
    a_slope_nv_load: assert property ($rose(nv_loaded_r) && !$past(wr_ok && hit_sl1)
        |-> slope1_r == $past(SLOPE_NV_CH1)) else $error("stored slope not loaded"); // R8
    a_readback_word: assert property ((CE && rd_ok && hit_rb1) |=> REG_ACK
        && REG_RDATA == {$past(adc1_sync_r), dual_dac_slew_pkg::READBACK_LOW}) else $error("readback word wrong"); // R10
    a_live_readonly: assert property ((CE && REG_WR && (hit_lv1 || hit_lv2)) |=> REG_ERR && !REG_ACK)
        else $error("write to present output accepted"); // R11
    a_version_read: assert property ((CE && rd_ok && hit_ver) |=> REG_RDATA == FW_VERSION)
        else $error("version word wrong"); // R12
    a_slew_no_overshoot: assert property ((CE && !(wr_ok && hit_sp1) && DAC_CH1 <= setpoint1_r)
        |=> DAC_CH1 <= setpoint1_r) else $error("output passed the setpoint"); // R13

    c_slew_reaches: cover property (code1 != 5'h00 && DAC_CH1 != setpoint1_r ##1 DAC_CH1 == setpoint1_r);
    c_frame_end: cover property (FRAME_END);
    c_reply_waited: cover property (REPLY_GO && reply_ms != 8'h00);
    c_write_refused: cover property (REG_ERR);
endmodule : dual_dac_slew_register_map

// >>> hw/dual_dac_slew_pkg.sv
// constants, field layout, reset values and timing counts of the dual output register map
// assumes a 25 MHz system clock and 16-bit holding registers at their printed offsets
//
// What this block does
// [R1] node address held, 1 to DF, resets 0001
// [R2] framing word resets 0035: 9600, 8N1
// [R3] low delay byte: reply wait, max 63 ms
// [R4] high delay byte: extra end wait, max 48
// [R5] request ends after 3.5 character gap plus extra
// [R6] 16-bit setpoints, 0 negative, FFFF positive full scale
// [R7] slope code 0 immediate, each code doubles rate
// [R8] slope changes at once, reloaded from nonvolatile default
// [R9] volts per second equals percent rate times span/100
// [R10] read-only 8-bit readback word per channel
// [R11] read-only present DAC value per channel
// [R12] read-only firmware version word
// [R13] step toward setpoint each tick, never overshoot
package dual_dac_slew_pkg;

    // ************************************************************
    // register offsets
    // ************************************************************
    localparam logic [15:0] OFS_NODE_ADDR = 16'h9C41;
    localparam logic [15:0] OFS_FRAMING = 16'h9C42;
    localparam logic [15:0] OFS_DELAYS = 16'h9C43;
    localparam logic [15:0] OFS_VERSION = 16'h9C61;
    localparam logic [15:0] OFS_SETPOINT1 = 16'h9C71;
    localparam logic [15:0] OFS_SETPOINT2 = 16'h9C72;
    localparam logic [15:0] OFS_SLOPE1 = 16'h9C81;
    localparam logic [15:0] OFS_SLOPE2 = 16'h9C82;
    localparam logic [15:0] OFS_READBACK1 = 16'h9CA1;
    localparam logic [15:0] OFS_READBACK2 = 16'h9CA2;
    localparam logic [15:0] OFS_LIVE1 = 16'h9CB1;
    localparam logic [15:0] OFS_LIVE2 = 16'h9CB2;

    // ************************************************************
    // reset values, limits and fields
    // ************************************************************
    localparam logic [15:0] NODE_ADDR_RST = 16'h0001;
    localparam logic [15:0] NODE_ADDR_MIN = 16'h0001;
    localparam logic [15:0] NODE_ADDR_MAX = 16'h00DF;
    localparam logic [15:0] FRAMING_RST = 16'h0035;
    localparam logic [3:0] BAUD_CODE_MIN = 4'h5;
    localparam logic [3:0] BAUD_CODE_MAX = 4'h9;
    localparam logic [15:0] DELAYS_RST = 16'h0003;
    localparam int unsigned REPLY_DLY_LSB = 0;
    localparam int unsigned EOQ_DLY_LSB = 8;
    localparam logic [7:0] REPLY_DLY_MAX_MS = 8'h3F;
    localparam logic [7:0] EOQ_DLY_MAX_MS = 8'h30;
    localparam logic [15:0] SETPOINT_RST = 16'h0000;
    localparam logic [15:0] SLOPE_RST = 16'h0000;
    localparam logic [4:0] SLOPE_CODE_TOP = 5'h12;
    localparam logic [7:0] READBACK_LOW = 8'h00;

    // ************************************************************
    // timing
    // ************************************************************
    localparam longint unsigned CLK_HZ = 25000000;
    localparam longint unsigned MS_TIME = 1;
    localparam int unsigned MS_CYC_DFLT = int'(CLK_HZ * MS_TIME / 1000);
    localparam longint unsigned GAP_CHARS_X10 = 35;
    localparam longint unsigned CHAR_BITS = 10;
    localparam longint unsigned BAUD_DFLT = 9600;
    localparam longint unsigned GAP_DEN = 10 * BAUD_DFLT;
    localparam int unsigned GAP_CYC_DFLT = int'((CLK_HZ * GAP_CHARS_X10 * CHAR_BITS + GAP_DEN - 1) / GAP_DEN);
    localparam longint unsigned TOP_RATE_PCT_PER_S = 20480;
    localparam longint unsigned PCT_FULL = 100;
    localparam logic [31:0] STEP_TOP_Q16 = 32'((64'd1 << 32) * TOP_RATE_PCT_PER_S / (PCT_FULL * 1000));

    // ************************************************************
    // reply delay states
    // ************************************************************
    typedef enum logic [0:0] {
        REPLY_IDLE = 1'b0,
        REPLY_WAIT = 1'b1
    } reply_state_e;

endpackage : dual_dac_slew_pkg

// >>> test/host_model.sv
// host model: register accesses, character strobes and reply requests
// assumes a one cycle ack or err answer registered at the sampling edge itself
`timescale 1ns/10ps
module host_model (
    // clock
    input wire logic clk,
    // register port
    output logic [15:0] addr,
    output logic wr,
    output logic rd,
    output logic [15:0] wdata,
    input wire logic [15:0] rdata,
    input wire logic ack,
    input wire logic err,
    // strobes
    output logic rx_char,
    output logic reply_req
);
    // idle lines at time zero
    initial begin
        addr = 16'h0000;
        wr = 1'b0;
        rd = 1'b0;
        wdata = 16'h0000;
        rx_char = 1'b0;
        reply_req = 1'b0;
    end
    // request held to its sampling edge, answer taken just after that same edge
    task automatic xfer(input logic w, input logic [15:0] a, input logic [15:0] d,
        output logic [15:0] q, output logic [1:0] r);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= w;
        rd <= !w;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
        addr <= ~a; // no stale value on released lines
        wdata <= ~d;
        #1;
        q = rdata;
        r = {ack, err};
    endtask : xfer
    // one cycle strobe: 1 for a character, 0 for a reply request
    task automatic pulse(input logic sel);
        @(posedge clk);
        rx_char <= sel;
        reply_req <= !sel;
        @(posedge clk);
        rx_char <= 1'b0;
        reply_req <= 1'b0;
    endtask : pulse
endmodule : host_model

// >>> test/tb.sv
// self-checking bench of the dual output register map
// assumes host_model drives the register port and the strobes
`timescale 1ns/10ps
module tb;
    // ********
    // setup
    // ********
    localparam int unsigned MS = 20;
    localparam int unsigned GAP = 70;
    localparam logic [15:0] FW = 16'h2E71; // arbitrary value
    logic clk, sys_rst, wr, rd, ack, err, rx, fend, rq, go;
    logic [15:0] addr, wd, rdat, dac1, dac2, node, frm, q, prev, nv;
    logic [7:0] adc1, adc2;
    int unsigned n_fail, checked, n;
    dual_dac_slew_register_map #(.MS_CYC(MS), .GAP_CYC(GAP), .FW_VERSION(FW)) dut_u (
        .CLK(clk), .SYS_RST(sys_rst), .CE(1'b1), .REG_ADDR(addr), .REG_WR(wr), .REG_RD(rd),
        .REG_WDATA(wd), .REG_RDATA(rdat), .REG_ACK(ack), .REG_ERR(err), .SLOPE_NV_CH1(nv),
        .SLOPE_NV_CH2(nv), .ADC_PIN_CH1(adc1), .ADC_PIN_CH2(adc2), .DAC_CH1(dac1), .DAC_CH2(dac2),
        .NODE_ADDR(node), .FRAMING_SETUP(frm), .RX_CHAR(rx), .FRAME_END(fend), .REPLY_REQ(rq), .REPLY_GO(go));
    host_model host_u (.clk(clk), .addr(addr), .wr(wr), .rd(rd), .wdata(wd), .rdata(rdat), .ack(ack),
        .err(err), .rx_char(rx), .reply_req(rq));
    // free running clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // ********
    // helpers
    // ********
    function automatic logic [15:0] dly(input logic sel, input int unsigned ms);
        return 16'((sel ? GAP : 0) + ms * MS + 1);
    endfunction : dly
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wrc(input logic [15:0] a, input logic [15:0] d, input logic [1:0] exp);
        logic [15:0] v;
        logic [1:0] r;
        host_u.xfer(1'b1, a, d, v, r);
        chk("write answer", {14'h0, exp}, {14'h0, r});
    endtask : wrc
    task automatic rdc(input logic [15:0] a, input logic [15:0] exp);
        logic [15:0] v;
        logic [1:0] r;
        host_u.xfer(1'b0, a, 16'h0000, v, r);
        chk("read answer", 16'h0002, {14'h0, r});
        chk("read data", exp, v);
    endtask : rdc
    // cycles from a strobe to its answer pulse
    task automatic strobe(input logic sel, input logic [15:0] exp);
        int unsigned k;
        k = 0;
        host_u.pulse(sel);
        #1;
        while ((sel ? fend : go) !== 1'b1 && k < 5000) begin
            @(posedge clk);
            #1;
            k++;
        end
        chk("strobe delay", exp, 16'(k));
    endtask : strobe
    task automatic test_end(input string name);
        $display("test %s done, checks %0d mismatches %0d", name, checked, n_fail);
    endtask : test_end
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : report_and_stop
    // watchdog cuts a hang short
    initial begin
        repeat (10000) @(posedge clk);
        n_fail++;
        report_and_stop();
    end
    // ********
    // tests
    // ********
    initial begin
        n_fail = 0;
        checked = 0;
        sys_rst = 1'b1;
        adc1 = 8'h00;
        adc2 = 8'h00;
        nv = 16'h0000;
        void'($urandom(73));
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        rdc(dual_dac_slew_pkg::OFS_NODE_ADDR, 16'h0001);
        rdc(dual_dac_slew_pkg::OFS_FRAMING, 16'h0035);
        rdc(dual_dac_slew_pkg::OFS_DELAYS, 16'h0003);
        rdc(dual_dac_slew_pkg::OFS_SLOPE2, 16'h0000);
        rdc(dual_dac_slew_pkg::OFS_VERSION, FW);
        test_end("reset values");
        wrc(dual_dac_slew_pkg::OFS_NODE_ADDR, 16'h0000, 2'b01);
        wrc(dual_dac_slew_pkg::OFS_NODE_ADDR, 16'h00E0, 2'b01);
        wrc(dual_dac_slew_pkg::OFS_NODE_ADDR, 16'h00DF, 2'b10);
        chk("node pins", 16'h00DF, node);
        wrc(dual_dac_slew_pkg::OFS_FRAMING, 16'h0034, 2'b01);
        wrc(dual_dac_slew_pkg::OFS_FRAMING, 16'h0039, 2'b10);
        chk("framing pins", 16'h0039, frm);
        wrc(dual_dac_slew_pkg::OFS_DELAYS, 16'h0040, 2'b01);
        wrc(dual_dac_slew_pkg::OFS_DELAYS, 16'h3100, 2'b01);
        wrc(dual_dac_slew_pkg::OFS_DELAYS, 16'h303F, 2'b10);
        rdc(dual_dac_slew_pkg::OFS_DELAYS, 16'h303F);
        wrc(dual_dac_slew_pkg::OFS_VERSION, 16'h0000, 2'b01);
        wrc(dual_dac_slew_pkg::OFS_LIVE1, 16'h0000, 2'b01);
        wrc(dual_dac_slew_pkg::OFS_READBACK2, 16'h0000, 2'b01);
        wrc(16'h9C50, 16'h0000, 2'b01);
        test_end("limits and read only");
        @(posedge clk);
        adc1 <= 8'($urandom);
        adc2 <= 8'($urandom);
        repeat (3) @(posedge clk);
        rdc(dual_dac_slew_pkg::OFS_READBACK1, {adc1, 8'h00});
        rdc(dual_dac_slew_pkg::OFS_READBACK2, {adc2, 8'h00});
        test_end("readback");
        wrc(dual_dac_slew_pkg::OFS_DELAYS, 16'h0000, 2'b10);
        strobe(1'b1, dly(1'b1, 0));
        strobe(1'b0, dly(1'b0, 0));
        wrc(dual_dac_slew_pkg::OFS_DELAYS, 16'h0203, 2'b10);
        strobe(1'b1, dly(1'b1, 2));
        strobe(1'b0, dly(1'b0, 3));
        test_end("delays");
        for (int i = 0; i < 8; i++) begin
            q = (i < 2) ? {16{i[0]}} : 16'($urandom);
            wrc(dual_dac_slew_pkg::OFS_SETPOINT1 + 16'(i % 2), q, 2'b10);
            @(posedge clk);
            #1;
            chk("present value", q, (i % 2) ? dac2 : dac1);
            rdc(dual_dac_slew_pkg::OFS_LIVE1 + 16'(i % 2), q);
        end
        test_end("immediate setpoints");
        wrc(dual_dac_slew_pkg::OFS_SETPOINT1, 16'h0000, 2'b10);
        wrc(dual_dac_slew_pkg::OFS_SLOPE1, 16'h0013, 2'b01);
        wrc(dual_dac_slew_pkg::OFS_SLOPE1, 16'h0012, 2'b10);
        wrc(dual_dac_slew_pkg::OFS_SETPOINT1, 16'hFFFF, 2'b10);
        n = 0;
        prev = dac1;
        while (dac1 !== 16'hFFFF && n < 8 * MS) begin
            @(posedge clk);
            #1;
            n++;
            if (dac1 < prev) chk("slew direction", prev, dac1);
            prev = dac1;
        end
        chk("slew cycles", 16'h0001, 16'(n >= 4 * MS && n <= 5 * MS + 4));
        test_end("slew");
        @(posedge clk);
        nv <= 16'(1 + $urandom % 18);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        #1;
        chk("dac after reset", 16'h0000, dac1);
        rdc(dual_dac_slew_pkg::OFS_SLOPE1, nv);
        rdc(dual_dac_slew_pkg::OFS_SLOPE2, nv);
        rdc(dual_dac_slew_pkg::OFS_NODE_ADDR, 16'h0001);
        test_end("second reset");
        report_and_stop();
    end
endmodule : tb
